// [ldc_defines.vh]
/*
 * Constants for the link diagnostic error counter block: byte positions
 * of the counter block, ack status codes, frame limits and retry timing.
 * Assumes a 25 MHz system clock; included by bare name.
 */
`ifndef LDC_DEFINES_VH
`define LDC_DEFINES_VH

// ****************************************************************
// Byte positions in the counter block
// ****************************************************************
`define LDC_ACK_CRC_ERROR_COUNT 5'h00
`define LDC_ACK_TIMEOUT_COUNT 5'h01
`define LDC_CONTENTION_COUNT 5'h02
`define LDC_BAD_ACK_STATUS_COUNT 5'h03
`define LDC_RETURNED_MESSAGE_COUNT 5'h04
`define LDC_REMOTE_MEMORY_FULL_COUNT 5'h05
`define LDC_MASTERSHIP_TIMEOUT_COUNT 5'h06
`define LDC_FAILED_HANDOVER_COUNT 5'h07
`define LDC_STATUS_FRAME_HEARD_COUNT 5'h08
`define LDC_SHORT_FRAME_COUNT 5'h09
`define LDC_BAD_DESTINATION_COUNT 5'h0A
`define LDC_RX_ACK_NO_BUFFER_COUNT 5'h0B
`define LDC_FRAME_CRC_ERROR_COUNT 5'h0C
`define LDC_OVERSIZE_MESSAGE_COUNT 5'h0D
`define LDC_NO_BUFFER_ARRIVAL_COUNT 5'h0E
`define LDC_DUPLICATE_FRAME_COUNT 5'h0F
`define LDC_ABORT_COUNT 5'h10
`define LDC_TX_MESSAGE_COUNT 5'h11
`define LDC_RX_MESSAGE_COUNT 5'h13
`define LDC_LAST_BYTE 5'h14
`define LDC_NUM_BYTE_COUNTERS 17
`define LDC_BLOCK_BITS 168

// ****************************************************************
// Counter reset and limits
// ****************************************************************
`define LDC_COUNT_RESET 8'h00
`define LDC_COUNT_MAX 8'hFF
`define LDC_WORD_RESET 16'h0000

// ****************************************************************
// Frame checks and acknowledgment status
// ****************************************************************
`define LDC_MIN_FRAME_BYTES 10'h006
`define LDC_MAX_MESSAGE_BYTES 10'h0FA
`define LDC_ACK_STATUS_OK 8'h00
`define LDC_ACK_STATUS_MEM_FULL 8'h01
`define LDC_MAX_RETRIES 3'h5

// ****************************************************************
// Timing
// ****************************************************************
`define LDC_CLK_HZ 25000000
`define LDC_HOLD_MS 500
// Half a second of 25 MHz clocks, sized to the 24-bit hold timer
`define LDC_HOLD_CYCLES 24'hBEBC20

`endif

// [ldc_counters.v]
/*
 * Diagnostic error counters of a token-passing multidrop link station,
 * with the memory-full retry hold and a streamed counter-block reply.
 * Assumes one-cycle event pulses from the link driver, synchronous to clk.
 */
// How it works
// RULE1: bad CRC or I/O error on a received ack bumps byte 0.
// RULE2: ack wait expiry without an ack bumps byte 1.
// RULE3: detected link contention bumps byte 2, matching link error 93.
// RULE4: intact ack with nonzero status other than memory full bumps byte 3.
// RULE5: every message handed back to its sender bumps byte 4.
// RULE6: remote memory full bumps byte 5 and holds the message half a second.
// RULE7: at most five memory-full retries, then the message is returned.
// RULE8: taking mastership after the no-frame timeout bumps byte 6.
// RULE9: silent successor on handover resumes polling and bumps byte 7.
// RULE10: size checked before type, so byte 8 counts only status frames of six bytes or more.
// RULE11: frames under six bytes are rejected and bump byte 9.
// RULE12: status frames heard with recognizer disabled count as short frames.
// RULE13: wrong destination or source equal to destination bumps byte 10.
// RULE14: ack sent before a receive buffer was allocated bumps byte 11.
// RULE15: frames failing CRC are rejected and bump byte 12.
// RULE16: messages longer than 250 bytes bump byte 13.
// RULE17: a message arriving with no buffer allocated bumps byte 14.
// RULE18: a sender lacking an ack resends the frame as a duplicate.
// RULE19: repeated sequence and command/reply between polls is discarded, bumps byte 15.
// RULE20: a detected abort sequence bumps byte 16.
// RULE21: a 16-bit count of sent messages sits at byte 17.
// RULE22: a 16-bit count of received messages sits at byte 19.
// RULE23: a diagnostic read returns the whole block; request address is ignored.
// RULE24: byte counters saturate; everything clears to zero at reset.
`timescale 1ns/10ps
`default_nettype none
`include "ldc_defines.vh"

module ldc_counters #(
   parameter [23:0] HOLD_CYCLES = `LDC_HOLD_CYCLES
)
(
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Acknowledgment events
   input wire ack_crc_err,
   input wire ack_io_err,
   input wire ack_timeout,
   input wire ack_rx,
   input wire [7:0] ack_status,
   input wire ack_sent_no_buf,
   // Mastership events
   input wire contention,
   input wire master_grab,
   input wire handover_fail,
   input wire poll_seen,
   // Transmit side
   input wire msg_returned,
   input wire tx_success,
   // Receive frame check
   input wire frame_done,
   input wire frame_crc_ok,
   input wire [9:0] frame_len,
   input wire frame_is_status,
   input wire [7:0] frame_dst,
   input wire [7:0] frame_src,
   input wire [7:0] frame_seq,
   input wire frame_cmd_reply,
   input wire [7:0] station_addr,
   input wire addr_recog_en,
   input wire rx_buf_ready,
   input wire abort_seen,
   // Retry, polling and frame outcome
   output reg retry_go,
   output reg retry_return,
   output wire retry_waiting,
   output reg resume_polling,
   output reg frame_accept,
   output reg frame_discard,
   // Diagnostic read
   input wire diag_req,
   output wire diag_busy,
   output reg rsp_valid,
   output reg [7:0] rsp_data,
   output reg rsp_last,
   input wire rsp_ready
);

   // ****************************************************************
   // Frame classification
   // ****************************************************************
   wire crc_ok_frame;
   wire short_ev;
   wire status_ev;
   wire bad_dst_ev;
   wire msg_ok;
   wire oversize_ev;
   wire no_buf_ev;
   wire dup_ev;
   wire accept_ev;
   reg last_valid;
   reg [7:0] last_seq;
   reg last_cmd_reply;

   // RULE15 crc first
   assign crc_ok_frame = frame_done & frame_crc_ok;
   // RULE10 size before type
   // RULE11 short frames
   // RULE12 recognizer off
   assign short_ev = crc_ok_frame &
      ((frame_len < `LDC_MIN_FRAME_BYTES) | (~addr_recog_en & frame_is_status));
   // Only a status frame of six bytes or more reaches here
   assign status_ev = crc_ok_frame & ~short_ev & frame_is_status;
   // RULE13 address checks
   assign bad_dst_ev = crc_ok_frame & ~short_ev & ~frame_is_status &
      ((addr_recog_en & (frame_dst != station_addr)) | (frame_src == frame_dst));
   assign msg_ok = crc_ok_frame & ~short_ev & ~frame_is_status & ~bad_dst_ev;
   // RULE16 oversize message
   assign oversize_ev = msg_ok & (frame_len > `LDC_MAX_MESSAGE_BYTES);
   // RULE17 no buffer
   assign no_buf_ev = msg_ok & ~oversize_ev & ~rx_buf_ready;
   // RULE19 duplicate match
   // RULE18 resent frames
   assign dup_ev = msg_ok & ~oversize_ev & rx_buf_ready & last_valid &
      (frame_seq == last_seq) & (frame_cmd_reply == last_cmd_reply);
   assign accept_ev = msg_ok & ~oversize_ev & rx_buf_ready & ~dup_ev;

   // ****************************************************************
   // Duplicate tracking between polls
   // ****************************************************************
   // A poll in the same cycle as an accept still leaves the new entry
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         last_valid <= 1'b0;
         last_seq <= 8'h00;
         last_cmd_reply <= 1'b0;
      end
      else if (accept_ev)
      begin
         last_valid <= 1'b1;
         last_seq <= frame_seq;
         last_cmd_reply <= frame_cmd_reply;
      end
      else if (poll_seen)
      begin
         last_valid <= 1'b0;
      end
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frame_accept <= 1'b0;
         frame_discard <= 1'b0;
         resume_polling <= 1'b0;
      end
      else
      begin
         frame_accept <= accept_ev;
         frame_discard <= frame_done & ~accept_ev;
         // RULE9 resume polling
         resume_polling <= handover_fail;
      end
   end

   // ****************************************************************
   // Memory-full retry hold
   // ****************************************************************
   localparam [1:0] S_IDLE = 2'b01;
   localparam [1:0] S_WAIT = 2'b10;

   reg [1:0] state;
   reg [1:0] next_state;
   reg [23:0] hold_timer;
   reg [2:0] tries;
   wire mem_full_ev;
   wire exhaust_ev;
   wire start_hold;

   assign mem_full_ev = ack_rx & (ack_status == `LDC_ACK_STATUS_MEM_FULL);
   // RULE7 retry limit
   assign exhaust_ev = mem_full_ev & (state == S_IDLE) & (tries == `LDC_MAX_RETRIES);
   // RULE6 start half-second hold
   assign start_hold = mem_full_ev & (state == S_IDLE) & (tries != `LDC_MAX_RETRIES);
   assign retry_waiting = (state == S_WAIT);

   always @*
   begin
      case (state)
         S_IDLE:
         begin
            if (start_hold)
               next_state = S_WAIT;
            else
               next_state = S_IDLE;
         end
         S_WAIT:
         begin
            if (hold_timer == 24'h000000)
               next_state = S_IDLE;
            else
               next_state = S_WAIT;
         end
         default:
            next_state = S_IDLE;
      endcase
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= S_IDLE;
         hold_timer <= 24'h000000;
         tries <= 3'h0;
         retry_go <= 1'b0;
         retry_return <= 1'b0;
      end
      else
      begin
         state <= next_state;
         retry_go <= 1'b0;
         retry_return <= 1'b0;
         if (start_hold)
         begin
            hold_timer <= HOLD_CYCLES - 24'h000001;
         end
         else if (state == S_WAIT)
         begin
            if (hold_timer == 24'h000000)
            begin
               // RULE6 retry after hold
               retry_go <= 1'b1;
               tries <= tries + 3'h1;
            end
            else
            begin
               hold_timer <= hold_timer - 24'h000001;
            end
         end
         if (exhaust_ev)
         begin
            // RULE7 hand back to originator
            retry_return <= 1'b1;
            tries <= 3'h0;
         end
         else if (ack_rx & ~mem_full_ev & (state == S_IDLE))
         begin
            // Any other answer while idle ends this message's retry history
            tries <= 3'h0;
         end
      end
   end

   // ****************************************************************
   // Byte counters
   // ****************************************************************
   wire [16:0] cnt_ev;
   wire [`LDC_BLOCK_BITS-1:0] block;
   reg [15:0] tx_count;
   reg [15:0] rx_count;

   // RULE1 ack crc or io
   assign cnt_ev[0] = ack_crc_err | ack_io_err;
   // RULE2 ack timeout
   assign cnt_ev[1] = ack_timeout;
   // RULE3 contention
   assign cnt_ev[2] = contention;
   // RULE4 bad ack status
   assign cnt_ev[3] = ack_rx & (ack_status != `LDC_ACK_STATUS_OK) &
      (ack_status != `LDC_ACK_STATUS_MEM_FULL);
   // RULE5 returned messages
   assign cnt_ev[4] = msg_returned | exhaust_ev;
   // RULE6 memory full
   assign cnt_ev[5] = mem_full_ev;
   // RULE8 mastership grab
   assign cnt_ev[6] = master_grab;
   // RULE9 failed handover
   assign cnt_ev[7] = handover_fail;
   assign cnt_ev[8] = status_ev;
   assign cnt_ev[9] = short_ev;
   assign cnt_ev[10] = bad_dst_ev;
   // RULE14 ack without buffer
   assign cnt_ev[11] = ack_sent_no_buf;
   assign cnt_ev[12] = frame_done & ~frame_crc_ok;
   assign cnt_ev[13] = oversize_ev;
   assign cnt_ev[14] = no_buf_ev;
   assign cnt_ev[15] = dup_ev;
   // RULE20 abort sequence
   assign cnt_ev[16] = abort_seen;

   genvar gi;
   generate
      for (gi = 0; gi < `LDC_NUM_BYTE_COUNTERS; gi = gi + 1)
      begin : g_cnt
         reg [7:0] count;
         // RULE24 saturate and clear
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               count <= `LDC_COUNT_RESET;
            else if (cnt_ev[gi] && (count != `LDC_COUNT_MAX))
               count <= count + 8'h01;
         end
         assign block[gi*8 +: 8] = count;
      end
   endgenerate

   // Word counters wrap: a saturated traffic count says little
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_count <= `LDC_WORD_RESET;
         rx_count <= `LDC_WORD_RESET;
      end
      else
      begin
         // RULE21 sent messages
         if (tx_success)
            tx_count <= tx_count + 16'h0001;
         // RULE22 received messages
         if (accept_ev)
            rx_count <= rx_count + 16'h0001;
      end
   end

   // Low byte first in each word
   assign block[`LDC_TX_MESSAGE_COUNT*8 +: 16] = tx_count;
   assign block[`LDC_RX_MESSAGE_COUNT*8 +: 16] = rx_count;

   // ****************************************************************
   // Diagnostic read reply
   // ****************************************************************
   reg [4:0] idx;
   wire [4:0] idx_next;
   wire [7:0] byte_next;

   assign diag_busy = rsp_valid;
   assign idx_next = idx + 5'h01;
   // Live values: a count may move while the block streams out
   assign byte_next = block[{idx_next, 3'b000} +: 8];

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_last <= 1'b0;
         idx <= 5'h00;
      end
      else if (!rsp_valid)
      begin
         // RULE23 whole block per request
         if (diag_req)
         begin
            rsp_valid <= 1'b1;
            rsp_data <= block[7:0];
            rsp_last <= 1'b0;
            idx <= 5'h00;
         end
      end
      else if (rsp_ready)
      begin
         if (idx == `LDC_LAST_BYTE)
         begin
            rsp_valid <= 1'b0;
            rsp_last <= 1'b0;
         end
         else
         begin
            idx <= idx_next;
            rsp_data <= byte_next;
            rsp_last <= (idx_next == `LDC_LAST_BYTE);
         end
      end
   end

endmodule // ldc_counters
`default_nettype wire

// [ldc_monitor.sv]
/* Port checker for ldc_counters: frame outcomes, retry hold timing
   and reply streaming. Assumes one clock and an active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module ldc_monitor #(
   parameter [23:0] HOLD_CYCLES = 24'h000014
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Frame check
   input wire logic frame_done,
   input wire logic frame_crc_ok,
   input wire logic [9:0] frame_len,
   input wire logic [7:0] frame_dst,
   input wire logic [7:0] frame_src,
   input wire logic [7:0] station_addr,
   input wire logic addr_recog_en,
   input wire logic frame_discard,
   // Acks and mastership
   input wire logic handover_fail,
   input wire logic resume_polling,
   input wire logic ack_rx,
   input wire logic [7:0] ack_status,
   input wire logic retry_waiting,
   input wire logic retry_go,
   input wire logic retry_return,
   // Diagnostic reply
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_last
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Hold length so far; a counter since the hold is far beyond ##
   logic [23:0] wait_cnt;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         wait_cnt <= 24'h000000;
      else if (retry_waiting)
         wait_cnt <= wait_cnt + 24'h000001;
      else
         wait_cnt <= 24'h000000;
   crc_reject_a: assert property (
      frame_done && !frame_crc_ok |=> frame_discard) else $error("bad crc frame kept");
   short_reject_a: assert property (
      frame_done && frame_len < 10'h006 |=> frame_discard) else $error("short frame kept");
   dst_reject_a: assert property (
      frame_done && (frame_src == frame_dst || addr_recog_en && frame_dst != station_addr)
      |=> frame_discard) else $error("misaddressed frame kept");
   resume_poll_a: assert property (
      handover_fail |=> resume_polling) else $error("polling not resumed");
   hold_start_a: assert property (
      ack_rx && ack_status == 8'h01 && !retry_waiting |=> retry_waiting != retry_return)
      else $error("memory full not held");
   hold_keep_a: assert property (
      $rose(retry_waiting) |-> retry_waiting[*8]) else $error("hold cut short");
   hold_len_a: assert property (
      retry_go |-> wait_cnt == HOLD_CYCLES && !retry_waiting) else $error("hold length wrong");
   stall_hold_a: assert property (
      rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last))
      else $error("reply byte changed while stalled");
   reply_end_a: assert property (
      rsp_valid && rsp_ready && rsp_last |=> !rsp_valid) else $error("reply runs past end");
endmodule // ldc_monitor
bind ldc_counters ldc_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_mon (.clk(clk), .rst_n(rst_n),
   .frame_done(frame_done), .frame_crc_ok(frame_crc_ok), .frame_len(frame_len),
   .frame_dst(frame_dst), .frame_src(frame_src), .station_addr(station_addr),
   .addr_recog_en(addr_recog_en), .frame_discard(frame_discard),
   .handover_fail(handover_fail), .resume_polling(resume_polling), .ack_rx(ack_rx),
   .ack_status(ack_status), .retry_waiting(retry_waiting), .retry_go(retry_go),
   .retry_return(retry_return), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
   .rsp_data(rsp_data), .rsp_last(rsp_last));
`default_nettype wire

// [ldc_peer.sv]
/* Far-side station model: hands one frame to the station on request
   and repeats it as a duplicate when its ack counts as lost.
   Assumes the bench raises send for one cycle. */
`timescale 1ns/10ps
`default_nettype none
module ldc_peer (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Request from the bench
   input wire logic send,
   input wire logic noack,
   input wire logic [36:0] f,
   // Frame toward the station
   output logic frame_done,
   output logic [36:0] q
);
   logic pend;
   always @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         frame_done <= 1'b0;
         pend <= 1'b0;
         q <= 37'h0;
      end
      else if (send || pend)
      begin
         frame_done <= 1'b1;
         pend <= send && noack;
         if (send)
            q <= f;
      end
      // Released fields must not look valid
      else
      begin
         frame_done <= 1'b0;
         q <= ~q;
      end
endmodule // ldc_peer
`default_nettype wire

// [tb.sv]
/* Bench for ldc_counters: events, frames and memory-full acks, then
   full counter-block reads. Assumes ldc_peer and ldc_monitor. */
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int H = 20;
   logic clk, rst_n, ack_io_err, ack_rx, poll_seen, addr_recog_en, rx_buf_ready;
   logic diag_req, rsp_ready, send, noack;
   logic [7:0] ack_status, station_addr;
   logic [8:0] ev;
   logic [36:0] f;
   logic [7:0] ex [21];
   int bm [9] = '{0, 1, 2, 4, 6, 7, 11, 16, 17};
   int miscompares, check_count, k, n;
   wire [36:0] q;
   wire ack_crc_err, ack_timeout, contention, msg_returned, master_grab, handover_fail;
   wire ack_sent_no_buf, abort_seen, tx_success, frame_done, frame_crc_ok, frame_is_status;
   wire frame_cmd_reply, retry_go, retry_return, retry_waiting, resume_polling;
   wire frame_accept, frame_discard, diag_busy, rsp_valid, rsp_last;
   wire [9:0] frame_len;
   wire [7:0] frame_dst, frame_src, frame_seq, rsp_data;
   assign {tx_success, abort_seen, ack_sent_no_buf, handover_fail, master_grab,
      msg_returned, contention, ack_timeout, ack_crc_err} = ev;
   assign {frame_crc_ok, frame_len, frame_is_status, frame_dst, frame_src, frame_seq,
      frame_cmd_reply} = q;
   ldc_peer peer (.clk, .rst_n, .send, .noack, .f, .frame_done, .q);
   ldc_counters #(.HOLD_CYCLES(24'h000014)) dut (.clk, .rst_n, .ack_crc_err, .ack_io_err,
      .ack_timeout, .ack_rx, .ack_status, .ack_sent_no_buf, .contention, .master_grab,
      .handover_fail, .poll_seen, .msg_returned, .tx_success, .frame_done, .frame_crc_ok,
      .frame_len, .frame_is_status, .frame_dst, .frame_src, .frame_seq, .frame_cmd_reply,
      .station_addr, .addr_recog_en, .rx_buf_ready, .abort_seen, .retry_go, .retry_return,
      .retry_waiting, .resume_polling, .frame_accept, .frame_discard, .diag_req,
      .diag_busy, .rsp_valid, .rsp_data, .rsp_last, .rsp_ready);
   initial
   begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   task cmp8(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error %0t: byte %h, expected %h", $time, g, e);
      end
   endtask
   task cmp1(input logic g, input logic e);
      check_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error %0t: flag %b, expected %b", $time, g, e);
      end
   endtask
   task bump(input int b);
      if (b == 17 || b == 19)
         {ex[b+1], ex[b]} = {ex[b+1], ex[b]} + 16'h0001;
      else if (ex[b] != 8'hFF)
         ex[b] = ex[b] + 8'h01;
   endtask
   task ack(input logic [7:0] s);
      ack_rx = 1;
      ack_status = s;
      @(posedge clk);
      #1 ack_rx = 0;
   endtask
   // Odd bytes see one stalled cycle before acceptance
   task rd_blk;
      int j, t;
      diag_req = 1;
      @(posedge clk);
      #1 diag_req = 0;
      cmp1(diag_busy, 1'b1);
      for (j = 0; j < 21; j++)
      begin
         rsp_ready = !j[0];
         if (j[0])
         begin
            @(posedge clk);
            #1 rsp_ready = 1;
         end
         t = 0;
         while (rsp_valid !== 1'b1 && t < 50)
         begin
            @(posedge clk);
            #1 t++;
         end
         cmp8(rsp_data, ex[j]);
         cmp1(rsp_last, j == 20);
         @(posedge clk);
         #1;
      end
      rsp_ready = 0;
      cmp1(rsp_valid, 1'b0);
      cmp1(diag_busy, 1'b0);
   endtask
   task frm(input logic c, input logic [9:0] l, input logic s, input logic [7:0] d,
      input logic [7:0] sr, input logic [7:0] sq, input logic na, input int b);
      f = {c, l, s, d, sr, sq, 1'b0};
      noack = na;
      send = 1;
      @(posedge clk);
      #1 send = 0;
      @(posedge clk iff frame_done);
      #1 cmp1(frame_accept, b == 19);
      cmp1(frame_discard, b != 19);
      bump(b);
      repeat (3) @(posedge clk);
      #1;
   endtask
   task complete_run;
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge clk);
      miscompares++;
      complete_run;
   end
   initial
   begin
      {ev, ack_io_err, ack_rx, ack_status, poll_seen, diag_req, rsp_ready, send, noack} = '0;
      f = '0;
      station_addr = 8'h2A;
      addr_recog_en = 1;
      rx_buf_ready = 1;
      rst_n = 0;
      foreach (ex[i]) ex[i] = 8'h00;
      repeat (12) @(posedge clk);
      #1 rst_n = 1;
      rd_blk;
      $display("test reset done");
      for (k = 0; k < 9; k++)
      begin
         ev = 9'h001 << k;
         repeat (2) @(posedge clk);
         #1 bump(bm[k]);
         bump(bm[k]);
      end
      ev = 9'h004;
      repeat (260) @(posedge clk);
      #1 ev = 9'h001;
      ack_io_err = 1;
      for (k = 0; k < 260; k++) bump(2);
      bump(0);
      @(posedge clk);
      #1 ev = 9'h000;
      ack_io_err = 0;
      ack(8'h02);
      bump(3);
      rd_blk;
      $display("test events done");
      frm(0, 10'h014, 0, 8'h2A, 8'h05, 8'h01, 0, 12);
      frm(1, 10'h005, 0, 8'h2A, 8'h05, 8'h01, 0, 9);
      addr_recog_en = 0;
      frm(1, 10'h014, 1, 8'h00, 8'h05, 8'h01, 0, 9);
      addr_recog_en = 1;
      frm(1, 10'h014, 0, 8'h33, 8'h05, 8'h01, 0, 10);
      frm(1, 10'h014, 0, 8'h2A, 8'h2A, 8'h01, 0, 10);
      frm(1, 10'h0FB, 0, 8'h2A, 8'h05, 8'h01, 0, 13);
      frm(1, 10'h0FA, 0, 8'h2A, 8'h05, 8'h01, 0, 19);
      rx_buf_ready = 0;
      frm(1, 10'h014, 0, 8'h2A, 8'h05, 8'h02, 0, 14);
      rx_buf_ready = 1;
      frm(1, 10'h014, 0, 8'h2A, 8'h05, 8'h03, 1, 19);
      bump(15);
      poll_seen = 1;
      @(posedge clk);
      #1 poll_seen = 0;
      frm(1, 10'h014, 0, 8'h2A, 8'h05, 8'h03, 0, 19);
      rd_blk;
      $display("test frames done");
      for (k = 1; k <= 6; k++)
      begin
         ack(8'h01);
         bump(5);
         n = 0;
         if (k < 6)
         begin
            while (retry_go !== 1'b1 && n < 40)
            begin
               @(posedge clk);
               #1 n++;
            end
            cmp8(n[7:0], H);
         end
         else
         begin
            cmp1(retry_return, 1'b1);
            bump(4);
         end
      end
      rd_blk;
      $display("test retries done");
      rst_n = 0;
      @(posedge clk);
      #1 rst_n = 1;
      foreach (ex[i]) ex[i] = 8'h00;
      rd_blk;
      $display("test clear done");
      complete_run;
   end
endmodule // tb
`default_nettype wire
